// ===== fpccs_defines.vh
// constants of the floating-point compare, convert and square-root slice
// assumes inclusion by the slice, monitor and bench files; definitions, no logic
`ifndef FPCCS_DEFINES_VH
`define FPCCS_DEFINES_VH

// ************************************************
// instruction word fields (bit 31 = msb)
// ************************************************
`define FPCCS_MAJOR_HI      31
`define FPCCS_MAJOR_LO      26
`define FPCCS_MAJOR_FP      6'h16
`define FPCCS_FUNC_HI       10
`define FPCCS_FUNC_LO       7
`define FPCCS_SEL_HI        6
`define FPCCS_SEL_LO        4
`define FPCCS_FUNC_CMP      4'h4
`define FPCCS_FUNC_FLT      4'h5
`define FPCCS_FUNC_FINT     4'h6
`define FPCCS_FUNC_SQRT     4'h7

// ************************************************
// compare selector codes
// ************************************************
`define FPCCS_SEL_UN        3'h0
`define FPCCS_SEL_LT        3'h1
`define FPCCS_SEL_EQ        3'h2
`define FPCCS_SEL_LE        3'h3
`define FPCCS_SEL_GT        3'h4
`define FPCCS_SEL_NE        3'h5
`define FPCCS_SEL_GE        3'h6

// ************************************************
// values and configuration codes
// ************************************************
`define FPCCS_CAUSE_FP      5'h06
`define FPCCS_QNAN          32'hFFC00000
`define FPCCS_CAUSE_RST     5'h00
`define FPCCS_CFG_EXT       2'h2
`define FPCCS_AREA_SMALL    2'h1
`define FPCCS_AREA_FAST     2'h2

// ************************************************
// latencies in clk_sys cycles, per area setting
// ************************************************
`define FPCCS_LAT_CMP_0     5'h01
`define FPCCS_LAT_CMP_1     5'h03
`define FPCCS_LAT_FLT_0     5'h04
`define FPCCS_LAT_FLT_1     5'h06
`define FPCCS_LAT_FLT_2     5'h01
`define FPCCS_LAT_FINT_0    5'h05
`define FPCCS_LAT_FINT_1    5'h07
`define FPCCS_LAT_FINT_2    5'h02
`define FPCCS_LAT_SQRT_0    5'h1B
`define FPCCS_LAT_SQRT_1    5'h1D
`define FPCCS_LAT_SQRT_2    5'h17

// square-root iterations, two root bits per cycle
`define FPCCS_SQRT_STEPS    4'hD

`endif

// ===== fpccs_pipe_model.sv
// pipeline-side model: keeps its own copy of the destination register
// assumes results are retired only on the dest_we pulse
`timescale 1ns/1ps

module fpccs_pipe_model (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        dest_we,
  input  wire [31:0] dest_operand,
  output reg  [31:0] rf_dest
);
  // write-back only on dest_we; a trapped op must leave it alone
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rf_dest <= 32'h00000000;
    end else if (dest_we) begin
      rf_dest <= dest_operand;
    end
  end
endmodule

// ===== fpccs_sqrt.v
// iterative square root of a positive normal single-precision value
// assumes the caller filters specials and waits at least 14 cycles
`timescale 1ns/1ps
`include "fpccs_defines.vh"

module fpccs_sqrt (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        start,
  input  wire [31:0] operand,
  output wire [31:0] root_out
);

  reg  [51:0] rad;
  reg  [27:0] rem;
  reg  [25:0] root;
  reg  [3:0]  cnt;
  reg  [7:0]  exp_res;
  wire [53:0] s1;
  wire [53:0] s2;
  wire [8:0]  exp_sum;
  wire        rnd;

  // one restoring step: returns {remainder, root}
  function [53:0] sqrt_step;
    input [27:0] r;
    input [25:0] q;
    input [1:0]  pair;
    reg   [27:0] sh;
    reg   [27:0] trial;
    begin
      sh    = {r[25:0], pair};
      trial = {q[25:0], 2'b01};
      if (sh >= trial) begin
        sqrt_step = {sh - trial, q[24:0], 1'b1};
      end else begin
        sqrt_step = {sh, q[24:0], 1'b0};
      end
    end
  endfunction

  assign s1      = sqrt_step(rem, root, rad[51:50]);
  assign s2      = sqrt_step(s1[53:26], s1[25:0], rad[49:48]);
  assign exp_sum = ({1'b0, operand[30:23]} + 9'h07F) >> 1;

  // ************************************************
  // digit recurrence, two bits a cycle
  // ************************************************
  // odd unbiased exponent (even biased) takes one more shift
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rad     <= 52'h0;
      rem     <= 28'h0;
      root    <= 26'h0;
      cnt     <= 4'h0;
      exp_res <= 8'h00;
    end else if (start) begin
      rad     <= operand[23] ? {3'b000, 1'b1, operand[22:0], 25'h0}
                             : {2'b00, 1'b1, operand[22:0], 26'h0};
      rem     <= 28'h0;
      root    <= 26'h0;
      cnt     <= `FPCCS_SQRT_STEPS;
      exp_res <= exp_sum[7:0];
    end else if (cnt != 4'h0) begin
      rad  <= {rad[47:0], 4'h0};
      rem  <= s2[53:26];
      root <= s2[25:0];
      cnt  <= cnt - 4'h1;
    end
  end

  // round to nearest even; a carry rolls into the exponent
  assign rnd      = root[0] & ((rem != 28'h0) | root[1]);
  assign root_out = {1'b0, exp_res, root[23:1]} + {31'h0, rnd};

endmodule

// ===== fpccs_unit.v
// floating-point compare, int/float conversion and square-root slice
// assumes the pipeline issues one decoded word at a time on issue_ready
//
// Functional notes
// - compare decoded at function 0100; selector bits 4-6 pick test
// - denormal compare operand: result 0, denormal flag, cause 00110
// - ordered operands follow selector table; selector 111 returns 0
// - signalling NaN: invalid flag, cause set, 1 only for 000/101
// - quiet NaN: 000/101 give 1, 010 gives 0, ordered tests trap
// - on a floating-point exception the destination stays unchanged
// - compare takes 1 cycle at area 0 or 2, 3 cycles at area 1
// - compare exists only when float unit config is above zero
// - signed integer to float with rounding, no flags touched
// - int to float takes 4, 6 or 1 cycles by area setting
// - float to signed integer truncating toward zero
// - denormal, NaN, infinity or out of range input traps
// - float to int takes 5, 7 or 2 cycles by area setting
// - conversions and square root need extended float config
// - square root of source; denormal input traps with denormal flag
// - sqrt: signalling NaN or negative traps, quiet NaN, minus zero
// - square root takes 27, 29 or 23 cycles by area setting
`timescale 1ns/1ps
`include "fpccs_defines.vh"

module fpccs_unit (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        issue_valid,
  output wire        issue_ready,
  input  wire [31:0] instr,
  input  wire [31:0] src_a,
  input  wire [31:0] src_b,
  input  wire [1:0]  area_opt_level,
  input  wire [1:0]  float_unit_config,
  input  wire        flag_clear,
  output reg         done,
  output reg         dest_we,
  output reg  [31:0] dest_operand,
  output reg         fp_exception,
  output reg  [4:0]  exception_cause_code,
  output reg         invalid_op_flag,
  output reg         denormal_operand_flag,
  output reg         unsupported
);

  // ************************************************
  // state and captured operands
  // ************************************************
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg  [1:0]  state;
  reg  [4:0]  cnt;
  reg  [3:0]  func;
  reg  [2:0]  sel;
  reg  [31:0] op_a;
  reg  [31:0] op_b;

  wire [3:0]  in_func = instr[`FPCCS_FUNC_HI:`FPCCS_FUNC_LO];
  wire        accept  = issue_valid & issue_ready;
  wire        is_fp   = instr[`FPCCS_MAJOR_HI:`FPCCS_MAJOR_LO]
                        == `FPCCS_MAJOR_FP;
  wire        ext_cfg = float_unit_config == `FPCCS_CFG_EXT;
  reg         legal;
  reg  [4:0]  lat;
  wire [31:0] sqrt_root;

  assign issue_ready = state == ST_IDLE;

  // ************************************************
  // decode and latency selection at issue
  // ************************************************
  always @* begin
    legal = 1'b0;
    lat   = `FPCCS_LAT_CMP_0;
    if (is_fp) begin
      case (in_func)
        `FPCCS_FUNC_CMP: begin
          legal = float_unit_config != 2'h0;
          lat   = (area_opt_level == `FPCCS_AREA_SMALL)
                  ? `FPCCS_LAT_CMP_1 : `FPCCS_LAT_CMP_0;
        end
        `FPCCS_FUNC_FLT: begin
          legal = ext_cfg;
          lat   = (area_opt_level == `FPCCS_AREA_SMALL) ? `FPCCS_LAT_FLT_1 :
                  (area_opt_level == `FPCCS_AREA_FAST)  ? `FPCCS_LAT_FLT_2 :
                  `FPCCS_LAT_FLT_0;
        end
        `FPCCS_FUNC_FINT: begin
          legal = ext_cfg;
          lat   = (area_opt_level == `FPCCS_AREA_SMALL) ? `FPCCS_LAT_FINT_1 :
                  (area_opt_level == `FPCCS_AREA_FAST)  ? `FPCCS_LAT_FINT_2 :
                  `FPCCS_LAT_FINT_0;
        end
        `FPCCS_FUNC_SQRT: begin
          legal = ext_cfg;
          lat   = (area_opt_level == `FPCCS_AREA_SMALL) ? `FPCCS_LAT_SQRT_1 :
                  (area_opt_level == `FPCCS_AREA_FAST)  ? `FPCCS_LAT_SQRT_2 :
                  `FPCCS_LAT_SQRT_0;
        end
        default: begin
          legal = 1'b0;
          lat   = `FPCCS_LAT_CMP_0;
        end
      endcase
    end
  end

  // ************************************************
  // operand classification
  // ************************************************
  wire a_emax = op_a[30:23] == 8'hFF;
  wire b_emax = op_b[30:23] == 8'hFF;
  wire a_mnz  = op_a[22:0] != 23'h0;
  wire b_mnz  = op_b[22:0] != 23'h0;
  wire a_dnz  = (op_a[30:23] == 8'h00) & a_mnz;
  wire b_dnz  = (op_b[30:23] == 8'h00) & b_mnz;
  wire a_zero = op_a[30:0] == 31'h0;
  wire b_zero = op_b[30:0] == 31'h0;
  wire a_nan  = a_emax & a_mnz;
  wire b_nan  = b_emax & b_mnz;
  wire a_snan = a_nan & ~op_a[22];
  wire b_snan = b_nan & ~op_b[22];
  wire a_inf  = a_emax & ~a_mnz;

  // ************************************************
  // compare of src_b against src_a
  // ************************************************
  // plus and minus zero compare equal
  wire c_eq = (a_zero & b_zero) | (op_a == op_b);
  wire c_lt = ~c_eq & ((op_b[31] & ~op_a[31]) |
              (~op_b[31] & ~op_a[31] & (op_b[30:0] < op_a[30:0])) |
              (op_b[31] & op_a[31] & (op_b[30:0] > op_a[30:0])));
  wire c_gt = ~c_eq & ~c_lt;
  wire sel_unord = (sel == `FPCCS_SEL_UN) | (sel == `FPCCS_SEL_NE);
  wire sel_order = (sel == `FPCCS_SEL_LT) | (sel == `FPCCS_SEL_LE) |
                   (sel == `FPCCS_SEL_GT) | (sel == `FPCCS_SEL_GE);

  reg        c_rel;
  reg        c_res;
  reg        c_io;
  reg        c_do;

  always @* begin
    case (sel)
      `FPCCS_SEL_LT: c_rel = c_lt;
      `FPCCS_SEL_EQ: c_rel = c_eq;
      `FPCCS_SEL_LE: c_rel = c_lt | c_eq;
      `FPCCS_SEL_GT: c_rel = c_gt;
      `FPCCS_SEL_NE: c_rel = ~c_eq;
      `FPCCS_SEL_GE: c_rel = c_gt | c_eq;
      default:       c_rel = 1'b0; // unordered and 111 give 0
    endcase
  end

  // denormal wins over NaN, signalling over quiet
  always @* begin
    c_res = c_rel;
    c_io  = 1'b0;
    c_do  = 1'b0;
    if (a_dnz | b_dnz) begin
      c_res = 1'b0;
      c_do  = 1'b1;
    end else if (a_snan | b_snan) begin
      c_res = sel_unord;
      c_io  = 1'b1;
    end else if (a_nan | b_nan) begin
      c_res = sel_unord;
      c_io  = sel_order;
    end
  end

  // ************************************************
  // signed integer to float, nearest even
  // ************************************************
  wire [31:0] i_abs = op_a[31] ? (~op_a + 32'h1) : op_a;
  reg  [5:0]  i_lz;
  reg  [31:0] i_norm;
  reg  [7:0]  i_exp;
  reg         i_rnd;
  reg  [31:0] flt_res;
  integer     k;

  // priority scan; the last hit is the leading one
  always @* begin
    i_lz = 6'h00;
    for (k = 0; k < 32; k = k + 1) begin
      if (i_abs[k]) begin
        i_lz = 6'd31 - k[5:0];
      end
    end
    i_norm  = i_abs << i_lz;
    i_exp   = 8'h9E - {2'b00, i_lz};
    i_rnd   = i_norm[7] & ((i_norm[6:0] != 7'h0) | i_norm[8]);
    flt_res = {op_a[31], i_exp, i_norm[30:8]} + {31'h0, i_rnd};
    if (i_abs == 32'h0) begin
      flt_res = 32'h0;
    end
  end

  // ************************************************
  // float to signed integer, truncating
  // ************************************************
  // biased exponent 158 is 2^31; only minus 2^31 fits there
  wire        f_big   = op_a[30:23] > 8'h9D;
  wire        f_min   = op_a[31] & (op_a[30:23] == 8'h9E) & ~a_mnz;
  wire [7:0]  f_shift = 8'h9E - op_a[30:23];
  wire [31:0] f_mag   = {1'b1, op_a[22:0], 8'h00} >> f_shift[4:0];
  reg  [31:0] fint_res;
  reg         f_io;

  always @* begin
    f_io = a_nan | a_inf | (f_big & ~f_min);
    if (op_a[30:23] < 8'h7F) begin
      fint_res = 32'h0; // magnitude below one
    end else if (f_min) begin
      fint_res = 32'h80000000;
    end else begin
      fint_res = op_a[31] ? (~f_mag + 32'h1) : f_mag;
    end
  end

  // ************************************************
  // square root special cases
  // ************************************************
  reg  [31:0] s_res;
  reg         s_io;

  always @* begin
    s_io  = 1'b0;
    s_res = sqrt_root;
    if (a_snan) begin
      s_res = `FPCCS_QNAN;
      s_io  = 1'b1;
    end else if (a_nan) begin
      s_res = `FPCCS_QNAN;
    end else if (op_a[31] & ~a_zero) begin
      s_res = `FPCCS_QNAN;
      s_io  = 1'b1;
    end else if (a_zero | a_inf) begin
      s_res = op_a; // keeps minus zero
    end
  end

  fpccs_sqrt u_sqrt (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .start    (accept & legal & (in_func == `FPCCS_FUNC_SQRT)),
    .operand  (src_a),
    .root_out (sqrt_root)
  );

  // ************************************************
  // commit selection
  // ************************************************
  reg  [31:0] res;
  reg         set_io;
  reg         set_do;

  always @* begin
    res    = 32'h0;
    set_io = 1'b0;
    set_do = 1'b0;
    case (func)
      `FPCCS_FUNC_CMP: begin
        res    = {31'h0, c_res};
        set_io = c_io;
        set_do = c_do;
      end
      `FPCCS_FUNC_FLT: begin
        res = flt_res;
      end
      `FPCCS_FUNC_FINT: begin
        res    = fint_res;
        set_do = a_dnz;
        set_io = ~a_dnz & f_io;
      end
      `FPCCS_FUNC_SQRT: begin
        res    = s_res;
        set_do = a_dnz;
        set_io = ~a_dnz & s_io;
      end
      default: begin
        res = 32'h0;
      end
    endcase
  end

  wire commit = (state == ST_RUN) & (cnt == 5'h01);
  wire trap   = set_io | set_do;

  // ************************************************
  // sequencer and result registers
  // ************************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state                <= ST_IDLE;
      cnt                  <= 5'h00;
      func                 <= 4'h0;
      sel                  <= 3'h0;
      op_a                 <= 32'h0;
      op_b                 <= 32'h0;
      done                 <= 1'b0;
      dest_we              <= 1'b0;
      dest_operand         <= 32'h0;
      fp_exception         <= 1'b0;
      exception_cause_code <= `FPCCS_CAUSE_RST;
      unsupported          <= 1'b0;
    end else begin
      done         <= 1'b0;
      dest_we      <= 1'b0;
      fp_exception <= 1'b0;
      unsupported  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (accept & legal) begin
            state <= ST_RUN;
            cnt   <= lat;
            func  <= in_func;
            sel   <= instr[`FPCCS_SEL_HI:`FPCCS_SEL_LO];
            op_a  <= src_a;
            op_b  <= src_b;
          end else if (accept) begin
            unsupported <= 1'b1;
          end
        end
        ST_RUN: begin
          if (commit) begin
            state <= ST_IDLE;
            done  <= 1'b1;
            if (trap) begin
              fp_exception         <= 1'b1;
              exception_cause_code <= `FPCCS_CAUSE_FP;
            end else begin
              dest_we      <= 1'b1;
              dest_operand <= res;
            end
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // sticky status flags
  // ************************************************
  // a trap in the clearing cycle still lands
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      invalid_op_flag       <= 1'b0;
      denormal_operand_flag <= 1'b0;
    end else begin
      invalid_op_flag       <= (commit & set_io) |
                               (invalid_op_flag & ~flag_clear);
      denormal_operand_flag <= (commit & set_do) |
                               (denormal_operand_flag & ~flag_clear);
    end
  end

endmodule

// ===== fpccs_unit_monitor.sv
// concurrent checks on the ports of the fp compare/convert/sqrt slice
// assumes the one clk_sys domain and the async active-high rst
`timescale 1ns/1ps
`include "fpccs_defines.vh"

// ************************************************
// checker module
// ************************************************
module fpccs_unit_monitor (
  input wire        clk_sys,
  input wire        rst,
  input wire        issue_valid,
  input wire        issue_ready,
  input wire [31:0] instr,
  input wire [31:0] src_a,
  input wire [31:0] src_b,
  input wire [1:0]  area_opt_level,
  input wire [1:0]  float_unit_config,
  input wire        flag_clear,
  input wire        done,
  input wire        dest_we,
  input wire [31:0] dest_operand,
  input wire        fp_exception,
  input wire [4:0]  exception_cause_code,
  input wire        invalid_op_flag,
  input wire        denormal_operand_flag,
  input wire        unsupported
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // decode of the word taken this edge
  wire       take = issue_valid && issue_ready;
  wire       fpop = take && instr[31:26] == `FPCCS_MAJOR_FP;
  wire [3:0] fn   = instr[10:7];
  wire       cmp  = fpop && fn == `FPCCS_FUNC_CMP;
  wire       ext  = fpop && fn > `FPCCS_FUNC_CMP && fn <= `FPCCS_FUNC_SQRT;
  wire       fast = area_opt_level == `FPCCS_AREA_FAST;

  a_cmp_fast_lat: assert property (cmp && float_unit_config != 2'h0 &&
    area_opt_level != `FPCCS_AREA_SMALL |=> !done ##1 done)
    else $error("compare not done after one cycle");
  a_cmp_small_lat: assert property (cmp && float_unit_config != 2'h0 &&
    area_opt_level == `FPCCS_AREA_SMALL
    |=> !done ##1 !done ##1 !done ##1 done)
    else $error("compare not done after three cycles");
  a_fint_fast_lat: assert property (fpop && fn == `FPCCS_FUNC_FINT &&
    float_unit_config == `FPCCS_CFG_EXT && fast |=> !done ##1 !done ##1 done)
    else $error("float to int not done after two cycles");
  a_sqrt_fast_lat: assert property (fpop && fn == `FPCCS_FUNC_SQRT &&
    float_unit_config == `FPCCS_CFG_EXT && fast |-> ##24 done)
    else $error("square root not done after 23 cycles");
  a_cmp_needs_cfg: assert property (cmp && float_unit_config == 2'h0
    |=> unsupported && !done)
    else $error("compare ran without a float unit");
  a_ext_needs_cfg: assert property (ext &&
    float_unit_config != `FPCCS_CFG_EXT |=> unsupported && !done)
    else $error("extended op ran without extended config");
  a_done_one_kind: assert property (done |-> dest_we != fp_exception)
    else $error("done without exactly one of write or exception");
  a_dest_only_we: assert property ($changed(dest_operand) |-> dest_we)
    else $error("destination changed without a write");
  a_cause_value: assert property ($changed(exception_cause_code) ||
    fp_exception |-> exception_cause_code == `FPCCS_CAUSE_FP && fp_exception)
    else $error("cause code not loaded with the fp cause");
  a_flag_sticky: assert property ($fell(invalid_op_flag) ||
    $fell(denormal_operand_flag) |-> $past(flag_clear))
    else $error("status flag cleared without a clear request");
  a_flag_on_trap: assert property ($rose(invalid_op_flag) ||
    $rose(denormal_operand_flag) |-> fp_exception)
    else $error("status flag set without an exception");
endmodule

bind fpccs_unit fpccs_unit_monitor mon_u (
  .clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid),
  .issue_ready(issue_ready), .instr(instr), .src_a(src_a), .src_b(src_b),
  .area_opt_level(area_opt_level), .float_unit_config(float_unit_config),
  .flag_clear(flag_clear), .done(done), .dest_we(dest_we),
  .dest_operand(dest_operand), .fp_exception(fp_exception),
  .exception_cause_code(exception_cause_code),
  .invalid_op_flag(invalid_op_flag),
  .denormal_operand_flag(denormal_operand_flag), .unsupported(unsupported));

// ===== testbench.sv
// self-checking bench of the fp compare/convert/sqrt slice
// assumes the slice, its monitor and the pipeline model are compiled
`timescale 1ns/1ps
`include "fpccs_defines.vh"

module testbench;
  localparam int W = 0, I = 1, D = 2, U = 3;
  logic clk_sys = 1'b0, rst = 1'b1, issue_valid = 1'b0, flag_clear = 1'b0;
  logic [31:0] instr = 32'h0, src_a = 32'h0, src_b = 32'h0;
  logic [1:0] area_opt_level = 2'h0, float_unit_config = 2'h0;
  wire issue_ready, done, dest_we, fp_exception, unsupported;
  wire invalid_op_flag, denormal_operand_flag;
  wire [31:0] dest_operand, rf_dest;
  wire [4:0] exception_cause_code;
  int fail_count = 0, compares = 0, cyc = 0;
  logic [31:0] exp_dest = 32'h0;
  logic exp_io = 1'b0, exp_do = 1'b0;
  int cl[3] = '{1, 3, 1}, fl[3] = '{4, 6, 1};
  int il[3] = '{5, 7, 2}, sl[3] = '{27, 29, 23};

  fpccs_unit dut_u (.clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .instr(instr), .src_a(src_a), .src_b(src_b),
    .area_opt_level(area_opt_level), .float_unit_config(float_unit_config),
    .flag_clear(flag_clear), .done(done), .dest_we(dest_we),
    .dest_operand(dest_operand), .fp_exception(fp_exception),
    .exception_cause_code(exception_cause_code),
    .invalid_op_flag(invalid_op_flag),
    .denormal_operand_flag(denormal_operand_flag),
    .unsupported(unsupported));
  fpccs_pipe_model pipe_u (.clk_sys(clk_sys), .rst(rst), .dest_we(dest_we),
    .dest_operand(dest_operand), .rf_dest(rf_dest));

  // ************************************************
  // clock, watchdog and shared tasks
  // ************************************************
  always #4 clk_sys = ~clk_sys;
  // a hang in the handshake ends the run as a failure
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // issue one word, hold it to the taking edge, time and judge the answer
  task automatic run(input logic [3:0] fn, input logic [2:0] sel,
    input logic [31:0] a, input logic [31:0] b, input logic [1:0] ar,
    input logic [1:0] cf, input int lat, input int kind,
    input logic [31:0] res);
    int n;
    begin
      n = 0;
      instr = {`FPCCS_MAJOR_FP, 15'h0000, fn, sel, 4'h0};
      src_a = a;
      src_b = b;
      area_opt_level = ar;
      float_unit_config = cf;
      issue_valid = 1'b1;
      while (issue_ready !== 1'b1) begin
        @(posedge clk_sys); #1;
      end
      @(posedge clk_sys); #1;
      issue_valid = 1'b0;
      chk(issue_ready, kind == U);
      // n counts edges after the taking edge until the answer shows
      while (done !== 1'b1 && unsupported !== 1'b1 && n < 40) begin
        @(posedge clk_sys); #1;
        n++;
      end
      if (kind == W) exp_dest = res;
      if (kind == I) exp_io = 1'b1;
      if (kind == D) exp_do = 1'b1;
      chk(32'(n), 32'(lat));
      chk(fp_exception, kind == I || kind == D);
      chk(dest_we, kind == W);
      chk(unsupported, kind == U);
      chk(dest_operand, exp_dest);
      chk({invalid_op_flag, denormal_operand_flag}, {exp_io, exp_do});
      if (kind == I || kind == D) chk(exception_cause_code, 5'h06);
      // the model retires on the dest_we edge, one cycle after done shows
      @(posedge clk_sys); #1;
      chk(done, 1'b0);
      chk(rf_dest, exp_dest);
    end
  endtask

  task automatic clr();
    flag_clear = 1'b1;
    @(posedge clk_sys); #1;
    flag_clear = 1'b0;
    {exp_io, exp_do} = 2'b00;
    chk({invalid_op_flag, denormal_operand_flag}, 2'b00);
  endtask

  task automatic conclude();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'b0;
    // every selector on less, signed-zero equal, greater; quiet and signalling on all but 111
    for (int s = 0; s < 8; s++) begin
      run(4'h4, s[2:0], 32'h40000000, 32'h3F800000, 0, 1, 1, W,
        32'(8'h2A >> s & 1));
      run(4'h4, s[2:0], 32'h00000000, 32'h80000000, 0, 1, 1, W,
        32'(8'h4C >> s & 1));
      run(4'h4, s[2:0], 32'h3F800000, 32'h40000000, 0, 1, 1, W,
        32'(8'h70 >> s & 1));
      if (s < 7) begin
        run(4'h4, s[2:0], 32'h3F800000, 32'h7FC00000, 2, 1, 1,
          8'h5A >> s & 1 ? I : W, 32'(8'h21 >> s & 1));
        run(4'h4, s[2:0], 32'h7F800001, 32'h3F800000, 0, 2, 1, I, 0);
      end
      clr();
    end
    run(4'h4, 3'h1, 32'h00000001, 32'h7F800001, 0, 1, 1, D, 0);
    clr();
    // latency of each op at each area setting, one idle cycle between words
    for (int ar = 0; ar < 3; ar++) begin
      run(4'h4, 3'h2, 32'h3F800000, 32'h3F800000, ar, 1, cl[ar], W, 1);
      run(4'h5, 3'h0, 32'h3, 0, ar, 2, fl[ar], W, 32'h40400000);
      run(4'h6, 3'h0, 32'h406CCCCD, 0, ar, 2, il[ar], W, 3);
      run(4'h7, 3'h0, 32'h40800000, 0, ar, 2, sl[ar], W, 32'h40000000);
    end
    run(4'h5, 3'h0, 32'hFFFFFFFF, 0, 2, 2, 1, W, 32'hBF800000);
    run(4'h5, 3'h0, 32'h01000001, 0, 2, 2, 1, W, 32'h4B800000);
    run(4'h6, 3'h0, 32'hC0200000, 0, 2, 2, 2, W, 32'hFFFFFFFE);
    run(4'h6, 3'h0, 32'hCF000000, 0, 2, 2, 2, W, 32'h80000000);
    run(4'h6, 3'h0, 32'h3F000000, 0, 2, 2, 2, W, 0);
    run(4'h6, 3'h0, 32'h4F000000, 0, 2, 2, 2, I, 0);
    run(4'h6, 3'h0, 32'h7F800000, 0, 2, 2, 2, I, 0);
    run(4'h6, 3'h0, 32'h00400000, 0, 2, 2, 2, D, 0);
    clr();
    run(4'h7, 3'h0, 32'h41100000, 0, 2, 2, 23, W, 32'h40400000);
    run(4'h7, 3'h0, 32'h7FC00000, 0, 2, 2, 23, W, 32'hFFC00000);
    run(4'h7, 3'h0, 32'h80000000, 0, 2, 2, 23, W, 32'h80000000);
    run(4'h7, 3'h0, 32'hC0800000, 0, 2, 2, 23, I, 0);
    run(4'h7, 3'h0, 32'h7F800001, 0, 2, 2, 23, I, 0);
    run(4'h7, 3'h0, 32'h00000001, 0, 2, 2, 23, D, 0);
    // words the configuration does not allow, and an undefined function
    run(4'h4, 3'h1, 32'h40000000, 32'h3F800000, 0, 0, 0, U, 0);
    run(4'h5, 3'h0, 32'h3, 0, 0, 1, 0, U, 0);
    run(4'h6, 3'h0, 32'h40000000, 0, 0, 1, 0, U, 0);
    run(4'h7, 3'h0, 32'h40800000, 0, 2, 0, 0, U, 0);
    run(4'h3, 3'h0, 32'h40800000, 0, 0, 2, 0, U, 0);
    conclude();
  end
endmodule
